// File: hdl/ifd_decoder.sv
// ifd_decoder: decode-stage field extraction, displacement, target and rotate mask forming
`default_nettype none
module ifd_decoder
  import ifd_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // fetched instruction
  input  wire logic        instr_valid_in,
  input  wire logic [31:0] instr_in,
  input  wire logic [63:0] current_instr_addr_in,
  input  wire logic        mode_64_in,
  // decoded word
  output logic             valid_out,
  output logic [5:0]       primary_opcode_out,
  // branch fields and targets
  output logic [4:0]       branch_options_out,
  output logic [4:0]       cond_select_index_out,
  output logic             absolute_select_out,
  output logic [63:0]      long_target_out,
  output logic [63:0]      cond_target_out,
  output logic             link_write_out,
  output logic [63:0]      link_value_out,
  // condition register fields
  output logic [4:0]       cond_bit_src_a_out,
  output logic [4:0]       cond_bit_src_b_out,
  output logic [4:0]       cond_bit_dest_out,
  output logic [2:0]       cond_field_dest_out,
  output logic [2:0]       cond_field_src_out,
  output logic [7:0]       cond_field_mask_out,
  // float fields
  output logic [4:0]       float_src_a_out,
  output logic [4:0]       float_src_b_out,
  output logic [4:0]       float_src_c_out,
  output logic [4:0]       float_dest_out,
  output logic [4:0]       float_store_src_out,
  output logic [7:0]       float_field_mask_out,
  output logic [3:0]       status_nibble_value_out,
  // integer fields
  output logic [4:0]       int_operand_a_out,
  output logic [4:0]       int_operand_b_out,
  output logic [4:0]       int_dest_out,
  output logic [63:0]      load_disp_out,
  output logic [63:0]      doubleword_disp_out,
  output logic             doubleword_disp_valid_out,
  output logic [4:0]       string_byte_count_out,
  output logic [63:0]      rotate_mask_out,
  // flags
  output logic             compare_wide_out,
  output logic             overflow_update_out,
  output logic             record_flag_out
);

  // extended displacements
  logic [63:0] long_ext;
  logic [63:0] cond_ext;
  logic [63:0] load_ext;
  logic [63:0] ds_ext;

  ifd_sext #(.W(LONG_W), .SH(WORD_SHIFT)) u_long_ext (
    .field_in  (instr_in[31-LONG_POS -: LONG_W]),
    .wide_in   (mode_64_in),
    .value_out (long_ext)
  );
  ifd_sext #(.W(COND_W), .SH(WORD_SHIFT)) u_cond_ext (
    .field_in  (instr_in[31-COND_POS -: COND_W]),
    .wide_in   (mode_64_in),
    .value_out (cond_ext)
  );
  ifd_sext #(.W(LOAD_W), .SH(NO_SHIFT)) u_load_ext (
    .field_in  (instr_in[31-LOAD_POS -: LOAD_W]),
    .wide_in   (mode_64_in),
    .value_out (load_ext)
  );
  ifd_sext #(.W(DS_W), .SH(WORD_SHIFT)) u_ds_ext (
    .field_in  (instr_in[31-DS_POS -: DS_W]),
    .wide_in   (1'b1),
    .value_out (ds_ext)
  );

  // registered state
  logic        valid_q, valid_d;
  logic [5:0]  opcode_q, opcode_d;
  logic [4:0]  f6_q, f6_d;
  logic [4:0]  f11_q, f11_d;
  logic [4:0]  f16_q, f16_d;
  logic [4:0]  f21_q, f21_d;
  logic        abs_q, abs_d;
  logic [63:0] long_tgt_q, long_tgt_d;
  logic [63:0] cond_tgt_q, cond_tgt_d;
  logic        link_wr_q, link_wr_d;
  logic [63:0] link_val_q, link_val_d;
  logic [2:0]  cfd_q, cfd_d;
  logic [2:0]  cfs_q, cfs_d;
  logic [7:0]  crm_q, crm_d;
  logic [7:0]  fm_q, fm_d;
  logic [3:0]  nib_q, nib_d;
  logic [63:0] load_q, load_d;
  logic [63:0] ds_q, ds_d;
  logic        ds_ok_q, ds_ok_d;
  logic [63:0] rmask_q, rmask_d;
  logic        cmpw_q, cmpw_d;
  logic        ovf_q, ovf_d;
  logic        rec_q, rec_d;

  // address arithmetic wraps at machine width
  function automatic logic [63:0] ifd_fit(input logic [63:0] v, input logic wide);
    ifd_fit = wide ? v : {UPPER_ZERO, v[31:0]};
  endfunction : ifd_fit

  // next values: fields are sliced with bit 0 as the word's msb
  always_comb begin
    logic [4:0] mb;
    logic [4:0] me;
    logic [4:0] idx;
    mb         = instr_in[31-FIELD21_POS -: REG_W];
    me         = instr_in[31-MASK_END_POS -: REG_W];
    idx        = 5'h00;
    valid_d    = instr_valid_in;
    opcode_d   = opcode_q;
    f6_d       = f6_q;
    f11_d      = f11_q;
    f16_d      = f16_q;
    f21_d      = f21_q;
    abs_d      = abs_q;
    long_tgt_d = long_tgt_q;
    cond_tgt_d = cond_tgt_q;
    link_wr_d  = 1'b0;
    link_val_d = link_val_q;
    cfd_d      = cfd_q;
    cfs_d      = cfs_q;
    crm_d      = crm_q;
    fm_d       = fm_q;
    nib_d      = nib_q;
    load_d     = load_q;
    ds_d       = ds_q;
    ds_ok_d    = ds_ok_q;
    rmask_d    = rmask_q;
    cmpw_d     = cmpw_q;
    ovf_d      = ovf_q;
    rec_d      = rec_q;
    if (instr_valid_in) begin
      opcode_d = instr_in[31-OPCODE_POS -: OPCODE_W];
      f6_d     = instr_in[31-FIELD6_POS -: REG_W];
      f11_d    = instr_in[31-FIELD11_POS -: REG_W];
      f16_d    = instr_in[31-FIELD16_POS -: REG_W];
      f21_d    = instr_in[31-FIELD21_POS -: REG_W];
      cfd_d    = instr_in[31-CFD_POS -: CF_W];
      cfs_d    = instr_in[31-CFS_POS -: CF_W];
      crm_d    = instr_in[31-CRM_POS -: MASK8_W];
      fm_d     = instr_in[31-FM_POS -: MASK8_W];
      nib_d    = instr_in[31-NIBBLE_POS -: NIBBLE_W];
      load_d   = load_ext;
      ds_d     = ds_ext;
      ds_ok_d  = mode_64_in;
      cmpw_d   = mode_64_in & instr_in[31-CMP_WIDE_POS];
      ovf_d    = instr_in[31-OVF_POS];
      rec_d    = instr_in[31-RECORD_POS];
      abs_d    = instr_in[31-ABS_POS];
      // targets: absolute uses the displacement alone, relative adds the address
      if (instr_in[31-ABS_POS] == ABS_ABSOLUTE) begin
        long_tgt_d = long_ext;
        cond_tgt_d = cond_ext;
      end else begin
        long_tgt_d = ifd_fit(current_instr_addr_in + long_ext, mode_64_in);
        cond_tgt_d = ifd_fit(current_instr_addr_in + cond_ext, mode_64_in);
      end
      // link register gets the next sequential address
      link_wr_d = instr_in[31-LINK_POS];
      if (instr_in[31-LINK_POS]) begin
        link_val_d = ifd_fit(current_instr_addr_in + INSTR_BYTES, mode_64_in);
      end
      // rotate mask over bits 32..63, wrapping when begin lies past end
      rmask_d = RST_WORD;
      for (int i = 0; i < ROT_OFFSET; i++) begin
        idx = 5'(i);
        if ((mb <= me) ? (idx >= mb && idx <= me) : (idx >= mb || idx <= me)) begin
          rmask_d[31-i] = 1'b1;
        end
      end
    end
  end

  // pipeline registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      valid_q    <= 1'b0;
      opcode_q   <= 6'h00;
      f6_q       <= 5'h00;
      f11_q      <= 5'h00;
      f16_q      <= 5'h00;
      f21_q      <= 5'h00;
      abs_q      <= ABS_RELATIVE;
      long_tgt_q <= RST_WORD;
      cond_tgt_q <= RST_WORD;
      link_wr_q  <= 1'b0;
      link_val_q <= RST_WORD;
      cfd_q      <= 3'h0;
      cfs_q      <= 3'h0;
      crm_q      <= 8'h00;
      fm_q       <= 8'h00;
      nib_q      <= 4'h0;
      load_q     <= RST_WORD;
      ds_q       <= RST_WORD;
      ds_ok_q    <= 1'b0;
      rmask_q    <= RST_WORD;
      cmpw_q     <= 1'b0;
      ovf_q      <= 1'b0;
      rec_q      <= 1'b0;
    end else begin
      valid_q    <= valid_d;
      opcode_q   <= opcode_d;
      f6_q       <= f6_d;
      f11_q      <= f11_d;
      f16_q      <= f16_d;
      f21_q      <= f21_d;
      abs_q      <= abs_d;
      long_tgt_q <= long_tgt_d;
      cond_tgt_q <= cond_tgt_d;
      link_wr_q  <= link_wr_d;
      link_val_q <= link_val_d;
      cfd_q      <= cfd_d;
      cfs_q      <= cfs_d;
      crm_q      <= crm_d;
      fm_q       <= fm_d;
      nib_q      <= nib_d;
      load_q     <= load_d;
      ds_q       <= ds_d;
      ds_ok_q    <= ds_ok_d;
      rmask_q    <= rmask_d;
      cmpw_q     <= cmpw_d;
      ovf_q      <= ovf_d;
      rec_q      <= rec_d;
    end
  end

  // outputs straight from the pipeline registers; shared fields fan out by name
  assign valid_out                 = valid_q;
  assign primary_opcode_out        = opcode_q;
  assign branch_options_out        = f6_q;
  assign cond_select_index_out     = f11_q;
  assign absolute_select_out       = abs_q;
  assign long_target_out           = long_tgt_q;
  assign cond_target_out           = cond_tgt_q;
  assign link_write_out            = link_wr_q;
  assign link_value_out            = link_val_q;
  assign cond_bit_src_a_out        = f11_q;
  assign cond_bit_src_b_out        = f16_q;
  assign cond_bit_dest_out         = f6_q;
  assign cond_field_dest_out       = cfd_q;
  assign cond_field_src_out        = cfs_q;
  assign cond_field_mask_out       = crm_q;
  assign float_src_a_out           = f11_q;
  assign float_src_b_out           = f16_q;
  assign float_src_c_out           = f21_q;
  assign float_dest_out            = f6_q;
  assign float_store_src_out       = f6_q;
  assign float_field_mask_out      = fm_q;
  assign status_nibble_value_out   = nib_q;
  assign int_operand_a_out         = f11_q;
  assign int_operand_b_out         = f16_q;
  assign int_dest_out              = f6_q;
  assign load_disp_out             = load_q;
  assign doubleword_disp_out       = ds_q;
  assign doubleword_disp_valid_out = ds_ok_q;
  assign string_byte_count_out     = f16_q;
  assign rotate_mask_out           = rmask_q;
  assign compare_wide_out          = cmpw_q;
  assign overflow_update_out       = ovf_q;
  assign record_flag_out           = rec_q;

  // checks on the decoded outputs
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_opcode_msb_first: assert property (instr_valid_in |=> primary_opcode_out == $past(instr_in[31:26]))
    else $error("opcode not taken from the top six bits");
  a_rel_cond_target: assert property (instr_valid_in && mode_64_in && !instr_in[1] |=>
    cond_target_out == $past(current_instr_addr_in) + {{48{$past(instr_in[15])}}, $past(instr_in[15:2]), 2'b00})
    else $error("relative conditional target wrong");
  a_abs_long_target: assert property (instr_valid_in && mode_64_in && instr_in[1] |=>
    long_target_out == {{38{$past(instr_in[25])}}, $past(instr_in[25:2]), 2'b00})
    else $error("absolute long target wrong");
  a_narrow_targets: assert property (instr_valid_in && !mode_64_in |=>
    long_target_out[63:32] == 32'h0000_0000 && cond_target_out[63:32] == 32'h0000_0000)
    else $error("upper half not clear in 32-bit mode");
  a_load_disp_ext: assert property (instr_valid_in && mode_64_in |=>
    load_disp_out == {{48{$past(instr_in[15])}}, $past(instr_in[15:0])})
    else $error("load displacement not sign-extended");
  a_link_next_addr: assert property (instr_valid_in && instr_in[0] && mode_64_in |=>
    link_write_out && link_value_out == $past(current_instr_addr_in) + 64'h0000_0000_0000_0004)
    else $error("link value not next sequential address");
  a_link_quiet: assert property (!(instr_valid_in && instr_in[0]) |=> !link_write_out)
    else $error("link written without link_update");
  a_rot_mask_ends: assert property (instr_valid_in |=>
    rotate_mask_out[31-$past(instr_in[10:6])] && rotate_mask_out[31-$past(instr_in[5:1])] &&
    rotate_mask_out[63:32] == 32'h0000_0000)
    else $error("rotate mask ends not set");
  a_compare_wide: assert property (instr_valid_in |=> compare_wide_out == $past(mode_64_in && instr_in[21]))
    else $error("compare width select wrong");
  a_overflow_gate: assert property (instr_valid_in |=> overflow_update_out == $past(instr_in[10]))
    else $error("overflow enable not passed on");
  a_fields_hold: assert property (!instr_valid_in |=> $stable(cond_field_mask_out) && $stable(float_dest_out))
    else $error("fields changed without a valid word");

  c_rel_branch: cover property (instr_valid_in && !instr_in[1] ##1 valid_out);
  c_abs_branch: cover property (instr_valid_in && instr_in[1] ##1 valid_out);
  c_wrap_mask:  cover property (instr_valid_in && instr_in[10:6] > instr_in[5:1]);
  c_link_write: cover property (link_write_out);

endmodule : ifd_decoder
`default_nettype wire

// File: hdl/ifd_pkg.sv
// ifd_pkg: field positions, widths and reset values of the instruction field decoder
`default_nettype none
package ifd_pkg;
  // field start bits, bit 0 being the most significant bit of the word
  localparam int OPCODE_POS   = 0;
  localparam int OPCODE_W     = 6;
  localparam int FIELD6_POS   = 6;   // branch_options, cond_bit_dest, float_dest, int_dest
  localparam int FIELD11_POS  = 11;  // cond_select_index, cond_bit_src_a, float_src_a, int_operand_a
  localparam int FIELD16_POS  = 16;  // cond_bit_src_b, float_src_b, int_operand_b, string_byte_count
  localparam int FIELD21_POS  = 21;  // float_src_c, mask_begin
  localparam int MASK_END_POS = 26;
  localparam int REG_W        = 5;
  localparam int CFD_POS      = 6;
  localparam int CFS_POS      = 11;
  localparam int CF_W         = 3;
  localparam int CRM_POS      = 12;
  localparam int FM_POS       = 7;
  localparam int MASK8_W      = 8;
  localparam int NIBBLE_POS   = 16;
  localparam int NIBBLE_W     = 4;
  localparam int CMP_WIDE_POS = 10;
  localparam int LONG_POS     = 6;
  localparam int LONG_W       = 24;
  localparam int COND_POS     = 16;
  localparam int COND_W       = 14;
  localparam int LOAD_POS     = 16;
  localparam int LOAD_W       = 16;
  localparam int DS_POS       = 16;
  localparam int DS_W         = 14;
  localparam int WORD_SHIFT   = 2;   // two zero bits appended on the right
  localparam int NO_SHIFT     = 0;
  localparam int OVF_POS      = 21;
  localparam int ABS_POS      = 30;
  localparam int LINK_POS     = 31;
  localparam int RECORD_POS   = 31;
  localparam int ROT_OFFSET   = 32;  // rotate mask bits are numbered from 32
  // encodings and constants
  localparam logic        ABS_RELATIVE = 1'b0;
  localparam logic        ABS_ABSOLUTE = 1'b1;
  localparam logic [63:0] INSTR_BYTES  = 64'h0000_0000_0000_0004;
  localparam logic [63:0] RST_WORD     = 64'h0000_0000_0000_0000;
  localparam logic [31:0] UPPER_ZERO   = 32'h0000_0000;
endpackage : ifd_pkg
`default_nettype wire

// File: hdl/ifd_sext.sv
// ifd_sext: sign-extends a displacement field to machine width, with optional zero bits appended
`default_nettype none
module ifd_sext
  import ifd_pkg::*;
#(
  parameter int W  = 14,
  parameter int SH = 2
) (
  // field and mode
  input  wire logic [W-1:0] field_in,
  input  wire logic         wide_in,
  // extended value, upper half zero in 32-bit mode
  output logic      [63:0]  value_out
);
  logic [63:0] ext;

  // extend as a signed quantity, then shift in the low zero bits
  always_comb begin
    ext       = 64'($signed(field_in)) << SH;
    value_out = wide_in ? ext : {UPPER_ZERO, ext[31:0]};
  end
endmodule : ifd_sext
`default_nettype wire

// File: tb/ifd_fetch_model.sv
// ifd_fetch_model: fetch unit stand-in that presents instruction words to the decoder
`default_nettype none
module ifd_fetch_model (
  // clock
  input  wire logic        clk_in,
  // fetched word towards the decoder
  output logic             valid_out,
  output logic [31:0]      instr_out,
  output logic [63:0]      addr_out,
  output logic             mode_64_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // quiet lines at time zero
  initial begin
    valid_out   = 1'b0;
    instr_out   = 32'h0000_0000;
    addr_out    = 64'h0000_0000_0000_0000;
    mode_64_out = 1'b1;
  end

  // wait for the next rising edge, then present one word; it stays on the lines until the next put or rest
  task automatic put(input logic [31:0] w, input logic [63:0] a, input logic m);
    @(posedge clk_in);
    valid_out   <= 1'b1;
    instr_out   <= w;
    addr_out    <= a;
    mode_64_out <= m;
  endtask : put

  // no word: valid drops, word and address lines turn to the inverse so a stale copy is never mistaken for data
  task automatic rest();
    @(posedge clk_in);
    valid_out <= 1'b0;
    instr_out <= ~instr_out;
    addr_out  <= ~addr_out;
  endtask : rest
endmodule : ifd_fetch_model
`default_nettype wire

// File: tb/tb_top.sv
// tb_top: self-checking testbench of the instruction field decoder
`default_nettype none
module tb_top
  import ifd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_in, rst_in, iv, mode, valid, absel, lwr, dsv, cwide, ovf, rec;
  logic [31:0] instr;
  logic [63:0] addr, lt, ct, lv, ld, dd, rm;
  logic [5:0]  opc;
  logic [4:0]  bo, csi, cba, cbb, cbd, fsa, fsb, fsc, fd, fss, ia, ib, idst, nb;
  logic [2:0]  cfd, cfs;
  logic [7:0]  cond_field_mask, fm;
  logic [3:0]  nib;
  logic [63:0] exp_link;
  int          n_errors, samples_checked;

  // clock and reset
  initial clk_in = 1'b0;
  always #4 clk_in = ~clk_in;

  ifd_fetch_model u_ifd_fetch_model (.clk_in(clk_in), .valid_out(iv), .instr_out(instr), .addr_out(addr),
    .mode_64_out(mode));

  ifd_decoder u_ifd_decoder (.clk_in(clk_in), .rst_in(rst_in), .instr_valid_in(iv), .instr_in(instr),
    .current_instr_addr_in(addr), .mode_64_in(mode), .valid_out(valid), .primary_opcode_out(opc),
    .branch_options_out(bo), .cond_select_index_out(csi), .absolute_select_out(absel),
    .long_target_out(lt), .cond_target_out(ct), .link_write_out(lwr), .link_value_out(lv),
    .cond_bit_src_a_out(cba), .cond_bit_src_b_out(cbb), .cond_bit_dest_out(cbd),
    .cond_field_dest_out(cfd), .cond_field_src_out(cfs), .cond_field_mask_out(cond_field_mask),
    .float_src_a_out(fsa), .float_src_b_out(fsb), .float_src_c_out(fsc), .float_dest_out(fd),
    .float_store_src_out(fss), .float_field_mask_out(fm), .status_nibble_value_out(nib),
    .int_operand_a_out(ia), .int_operand_b_out(ib), .int_dest_out(idst), .load_disp_out(ld),
    .doubleword_disp_out(dd), .doubleword_disp_valid_out(dsv), .string_byte_count_out(nb),
    .rotate_mask_out(rm), .compare_wide_out(cwide), .overflow_update_out(ovf), .record_flag_out(rec));

  // compare one value and count it
  task automatic chk(input logic [63:0] seen, input logic [63:0] expv);
    samples_checked++;
    if (seen !== expv) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, expv);
    end
  endtask : chk

  // 32-bit mode keeps the upper half zero
  function automatic logic [63:0] fit(input logic [63:0] v, input logic m);
    return m ? v : {32'h0000_0000, v[31:0]};
  endfunction : fit

  // expected decode of one word, worked out from the field layout
  task automatic verify(input logic [31:0] w, input logic [63:0] a, input logic m);
    logic [63:0] el, ec, er, es;
    int          mb, me;
    el = {{38{w[25]}}, w[25:2], 2'b00};
    ec = {{48{w[15]}}, w[15:2], 2'b00};
    es = ec;
    er = 64'h0000_0000_0000_0000;
    mb = w[10:6];
    me = w[5:1];
    if (w[1] == ABS_RELATIVE) begin
      el = el + a;
      ec = ec + a;
    end
    for (int i = 0; i < 32; i++) begin
      if ((mb <= me) ? (i >= mb && i <= me) : (i >= mb || i <= me)) er[31-i] = 1'b1;
    end
    if (w[0]) exp_link = fit(a + INSTR_BYTES, m);
    chk(valid, 1'b1);
    chk(opc, w[31:26]);
    chk(bo, w[25:21]);
    chk(cbd, w[25:21]);
    chk(fd, w[25:21]);
    chk(fss, w[25:21]);
    chk(idst, w[25:21]);
    chk(csi, w[20:16]);
    chk(cba, w[20:16]);
    chk(fsa, w[20:16]);
    chk(ia, w[20:16]);
    chk(cbb, w[15:11]);
    chk(fsb, w[15:11]);
    chk(ib, w[15:11]);
    chk(nb, w[15:11]);
    chk(fsc, w[10:6]);
    chk(cfd, w[25:23]);
    chk(cfs, w[20:18]);
    chk(cond_field_mask, w[19:12]);
    chk(fm, w[24:17]);
    chk(nib, w[15:12]);
    chk(absel, w[1]);
    chk(lt, fit(el, m));
    chk(ct, fit(ec, m));
    chk(lwr, w[0]);
    chk(lv, exp_link);
    chk(ld, fit({{48{w[15]}}, w[15:0]}, m));
    chk(dd, es);
    chk(dsv, m);
    chk(rm, er);
    chk(cwide, m & w[21]);
    chk(ovf, w[10]);
    chk(rec, w[0]);
  endtask : verify

  // one word alone, then a quiet cycle in which the fields must hold
  task automatic one(input logic [31:0] w, input logic [63:0] a, input logic m);
    u_ifd_fetch_model.put(w, a, m);
    u_ifd_fetch_model.rest();
    #1;
    verify(w, a, m);
    @(posedge clk_in);
    #1;
    chk(valid, 1'b0);
    chk(lwr, 1'b0);
    chk(opc, w[31:26]);
    chk(lv, exp_link);
  endtask : one

  // valid, link write, opcode, branch options, both targets, link value and rotate mask read zero while reset is held
  task automatic t_reset();
    #1;
    exp_link = 64'h0000_0000_0000_0000;
    chk({valid, lwr, opc, bo}, 64'h0000_0000_0000_0000);
    chk(lt | ct | lv | rm, 64'h0000_0000_0000_0000);
  endtask : t_reset

  // mixed words: both modes, relative and absolute, negative and positive displacements, wrap at 32 bits
  task automatic t_table();
    one(32'hFFFF_FFFF, 64'h0000_0000_0000_1000, 1'b1);
    one(32'hA5C3_0F96, 64'h1234_5678_9ABC_DEF0, 1'b1);
    one(32'h5A3C_F069, 64'h0000_0000_FFFF_FFF0, 1'b0);
    one(32'h4BFF_FFF0, 64'h0000_0000_0000_0400, 1'b0);
    one(32'h4800_0103, 64'h0000_0000_0000_0400, 1'b1);
    one(32'h4180_8000, 64'h8000_0000_0000_0000, 1'b1);
    one(32'h0000_0000, 64'hFFFF_FFFF_FFFF_FFFC, 1'b0);
  endtask : t_table

  // words on consecutive cycles, link set then clear
  task automatic t_back_to_back();
    u_ifd_fetch_model.put(32'h4800_0011, 64'h0000_0000_0000_2000, 1'b1);
    u_ifd_fetch_model.put(32'h7C21_5214, 64'h0000_0000_0000_2004, 1'b1);
    #1;
    verify(32'h4800_0011, 64'h0000_0000_0000_2000, 1'b1);
    u_ifd_fetch_model.rest();
    #1;
    verify(32'h7C21_5214, 64'h0000_0000_0000_2004, 1'b1);
  endtask : t_back_to_back

  // rotate masks: full, single bit and two wrapped spans
  task automatic t_rotate();
    int pr [4][2] = '{'{0, 31}, '{5, 5}, '{31, 0}, '{20, 3}};
    foreach (pr[k]) begin
      one(32'h5400_0000 | (32'(pr[k][0]) << 6) | (32'(pr[k][1]) << 1), 64'h0000_0000_0000_0100, k[0]);
    end
  endtask : t_rotate

  // reset in mid-run clears everything, then a word right after release
  task automatic t_midreset();
    one(32'h4800_0041, 64'h0000_0000_0000_3000, 1'b1);
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    t_reset();
    @(posedge clk_in);
    rst_in <= 1'b0;
    one(32'h4000_0021, 64'h0000_0000_0000_3100, 1'b1);
  endtask : t_midreset

  // counts and verdict
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // main sequence
  initial begin
    n_errors        = 0;
    samples_checked = 0;
    exp_link        = 64'h0000_0000_0000_0000;
    rst_in          = 1'b1;
    repeat (7) @(posedge clk_in);
    t_reset();
    @(posedge clk_in);
    rst_in <= 1'b0;
    t_table();
    t_back_to_back();
    t_rotate();
    t_midreset();
    give_verdict();
  end

  // watchdog: the run needs about 54 cycles
  initial begin
    #40000;
    n_errors++;
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
